// ==== inc/async_wr_params.svh ====
// Constants for the asynchronous write sequencer
`ifndef ASYNC_WR_PARAMS_SVH
`define ASYNC_WR_PARAMS_SVH
`define SETUP_FLD_W 4
`define STROBE_FLD_W 6
`define HOLD_FLD_W 3
`define TA_FLD_W 2
`define PHASE_CNT_W 7
`define SPACE_CNT 4
`define SPACE_W 2
`define WORD_W 32
`define WORD_BE_W 4
`define ACC_W 2
`define ACC_FIRST 2'h0
`define ACC_STEP 2'h1
`define ACC_LAST_8 2'h3
`define ACC_LAST_16 2'h1
`define BYTE_MASK 32'h000000FF
`define TA_ZERO 2'h0
`define CNT_ZERO 7'h00
`define CNT_ONE 7'h01
`define LAST_WR_RST 1'b1
`endif

// ==== inc/async_wr_pkg.sv ====
// Types shared by the asynchronous write sequencer
`include "async_wr_params.svh"
package async_wr_pkg;
    // Per chip-space configuration, one per select line
    typedef struct packed {
        logic ss;
        logic asize16;
        logic [`TA_FLD_W-1:0] ta;
        logic [`SETUP_FLD_W-1:0] w_setup;
        logic [`STROBE_FLD_W-1:0] w_strobe;
        logic [`HOLD_FLD_W-1:0] w_hold;
    } chip_space_config_s;
    typedef chip_space_config_s [`SPACE_CNT-1:0] chip_space_config_t;
    typedef enum logic [2:0] {ST_IDLE, ST_TURN, ST_SETUP, ST_STROBE, ST_HOLD} wr_state_e;
    typedef logic [`PHASE_CNT_W-1:0] phase_cnt_t;
endpackage

// ==== inc/phase_timer_if.sv ====
// Link between the sequencer and its phase timer
`timescale 1ns/1ns
`default_nettype none
interface phase_timer_if;
    import async_wr_pkg::*;
    logic load;
    phase_cnt_t load_val;
    logic pause;
    logic expired;
    modport ctrl (output load, output load_val, output pause, input expired);
    modport tmr (input load, input load_val, input pause, output expired);
endinterface
`default_nettype wire

// ==== hdl/phase_timer.sv ====
// Down counter timing turnaround, setup, strobe and hold phases
`timescale 1ns/1ns
`default_nettype none
`include "async_wr_params.svh"
module phase_timer (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    phase_timer_if.tmr tif
);
    import async_wr_pkg::*;
    phase_cnt_t count_r;

    // Loaded with the phase length; frozen while paused
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_r <= `CNT_ZERO;
        end else if (tif.load) begin
            count_r <= tif.load_val;
        end else if (!tif.pause && count_r != `CNT_ZERO) begin
            count_r <= count_r - `CNT_ONE;
        end
    end

    // Last cycle of a phase; a pause holds it open
    assign tif.expired = (count_r <= `CNT_ONE) && !tif.pause;
endmodule // phase_timer
`default_nettype wire

// ==== hdl/async_wr_seq.sv ====
// Asynchronous memory write cycle sequencer, normal and select-strobe modes
`timescale 1ns/1ns
`default_nettype none
`include "async_wr_params.svh"
module async_wr_seq #(
    parameter int ADDR_W = 23,
    parameter int DATA_W = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire async_wr_pkg::chip_space_config_t chip_space_config_i,
    input wire logic req_valid_i,
    input wire logic req_top_i,
    input wire logic [`SPACE_W-1:0] req_space_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [1:0] req_bank_i,
    input wire logic [`WORD_W-1:0] req_data_i,
    input wire logic [`WORD_BE_W-1:0] req_be_i,
    input wire logic read_done_i,
    input wire logic device_wait_in_i,
    input wire logic [DATA_W-1:0] data_io_i,
    output logic req_accept_o,
    output logic abandon_o,
    output logic done_o,
    output logic busy_o,
    output logic write_strobe_n_o,
    output logic [DATA_W/8-1:0] byte_enable_n_o,
    output logic [`SPACE_CNT-1:0] chip_select_n_o,
    output logic [ADDR_W-1:0] addr_out_o,
    output logic [1:0] bank_addr_out_o,
    output logic [DATA_W-1:0] data_io_o,
    output logic data_io_oe_o
);
    import async_wr_pkg::*;
    localparam int BE_W = DATA_W / 8;

    wr_state_e state_r, state_nxt;
    chip_space_config_s cfg_sel;
    phase_timer_if tif ();
    logic go_setup, last_acc, abandon_nxt, last_wr_r, ss_r, asize16_r;
    logic [`TA_FLD_W:0] ta_cnt;
    logic [`ACC_W-1:0] acc_r, acc_next;
    logic [`SPACE_W-1:0] space_r;
    logic [ADDR_W-1:0] base_r;
    logic [`WORD_W-1:0] word_r;
    logic [`WORD_BE_W-1:0] be_r;
    phase_cnt_t set_r, stb_r, hld_r;

    // Lane selection for one narrow access
    function automatic logic [DATA_W-1:0] lane_data(input logic [`WORD_W-1:0] w,
                                                    input logic [`ACC_W-1:0] a,
                                                    input logic wide);
        logic [`WORD_W-1:0] s;
        s = wide ? (w >> (a * 16)) : ((w >> (a * 8)) & `BYTE_MASK);
        return s[DATA_W-1:0];
    endfunction

    function automatic logic [BE_W-1:0] lane_be(input logic [`WORD_BE_W-1:0] b,
                                                input logic [`ACC_W-1:0] a,
                                                input logic wide);
        logic [`WORD_BE_W-1:0] s;
        s = wide ? (b >> (a * 2)) : (b >> a);
        return wide ? s[BE_W-1:0] : BE_W'(s[0]);
    endfunction

    phase_timer u_timer (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .tif(tif)
    );

    // Turnaround: none after a write, at least one after a read
    assign cfg_sel = chip_space_config_i[req_space_i];
    always_comb begin
        if (last_wr_r) begin
            ta_cnt = 3'h0;
        end else if (cfg_sel.ta == `TA_ZERO) begin
            ta_cnt = 3'h1;
        end else begin
            ta_cnt = {1'b0, cfg_sel.ta};
        end
    end

    assign last_acc = acc_r == (asize16_r ? `ACC_LAST_16 : `ACC_LAST_8);
    assign acc_next = `ACC_W'(acc_r + `ACC_STEP);
    assign tif.pause = (state_r == ST_STROBE) && device_wait_in_i;

    // Phase sequencing and timer loads
    always_comb begin
        state_nxt = state_r;
        go_setup = 1'b0;
        abandon_nxt = 1'b0;
        tif.load = 1'b0;
        tif.load_val = `CNT_ZERO;
        case (state_r)
            ST_IDLE: begin
                if (req_valid_i && req_top_i) begin
                    if (ta_cnt == 3'h0) begin
                        go_setup = 1'b1;
                    end else begin
                        state_nxt = ST_TURN;
                        tif.load = 1'b1;
                        tif.load_val = `PHASE_CNT_W'(ta_cnt);
                    end
                end
            end
            ST_TURN: begin
                if (tif.expired) begin
                    if (req_valid_i && req_top_i) begin
                        go_setup = 1'b1;
                    end else begin
                        state_nxt = ST_IDLE;
                        abandon_nxt = 1'b1;
                    end
                end
            end
            ST_SETUP: begin
                if (tif.expired) begin
                    state_nxt = ST_STROBE;
                    tif.load = 1'b1;
                    tif.load_val = stb_r;
                end
            end
            ST_STROBE: begin
                if (tif.expired) begin
                    state_nxt = ST_HOLD;
                    tif.load = 1'b1;
                    tif.load_val = hld_r;
                end
            end
            ST_HOLD: begin
                if (tif.expired) begin
                    if (!last_acc) begin
                        state_nxt = ST_SETUP;
                        tif.load = 1'b1;
                        tif.load_val = set_r;
                    end else if (req_valid_i && req_top_i) begin
                        if (ta_cnt == 3'h0) begin
                            go_setup = 1'b1;
                        end else begin
                            state_nxt = ST_TURN;
                            tif.load = 1'b1;
                            tif.load_val = `PHASE_CNT_W'(ta_cnt);
                        end
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (go_setup) begin
            state_nxt = ST_SETUP;
            tif.load = 1'b1;
            tif.load_val = `PHASE_CNT_W'(cfg_sel.w_setup) + `CNT_ONE;
        end
    end

    // State register
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Latched request and counts; counts only reload on a fresh request
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            space_r <= '0;
            base_r <= '0;
            word_r <= '0;
            be_r <= '0;
            ss_r <= 1'b0;
            asize16_r <= 1'b0;
            set_r <= `CNT_ZERO;
            stb_r <= `CNT_ZERO;
            hld_r <= `CNT_ZERO;
            acc_r <= `ACC_FIRST;
        end else if (go_setup) begin
            space_r <= req_space_i;
            base_r <= req_addr_i;
            word_r <= req_data_i;
            be_r <= req_be_i;
            ss_r <= cfg_sel.ss;
            asize16_r <= cfg_sel.asize16;
            set_r <= `PHASE_CNT_W'(cfg_sel.w_setup) + `CNT_ONE;
            stb_r <= `PHASE_CNT_W'(cfg_sel.w_strobe) + `CNT_ONE;
            hld_r <= `PHASE_CNT_W'(cfg_sel.w_hold) + `CNT_ONE;
            acc_r <= `ACC_FIRST;
        end else if (state_r == ST_HOLD && tif.expired && !last_acc) begin
            acc_r <= acc_next;
        end
    end

    // Write direction memory; cleared when a read cycle runs elsewhere
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_wr_r <= `LAST_WR_RST;
        end else if (go_setup) begin
            last_wr_r <= 1'b1;
        end else if (read_done_i) begin
            last_wr_r <= 1'b0;
        end
    end

    // Pin drive; a new setup is applied last so it wins the edge
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            write_strobe_n_o <= 1'b1;
            byte_enable_n_o <= '1;
            chip_select_n_o <= '1;
            addr_out_o <= '0;
            bank_addr_out_o <= '0;
            data_io_o <= '0;
            data_io_oe_o <= 1'b0;
        end else begin
            if (state_r == ST_SETUP && tif.expired) begin
                write_strobe_n_o <= 1'b0;
                byte_enable_n_o <= ~lane_be(be_r, acc_r, asize16_r);
                if (ss_r) begin
                    chip_select_n_o[space_r] <= 1'b0;
                end
            end
            if (state_r == ST_STROBE && tif.expired) begin
                write_strobe_n_o <= 1'b1;
                byte_enable_n_o <= '1;
                if (ss_r) begin
                    chip_select_n_o <= '1;
                end
            end
            if (state_r == ST_HOLD && tif.expired) begin
                if (last_acc) begin
                    addr_out_o <= '0;
                    bank_addr_out_o <= '0;
                    data_io_o <= '0;
                    data_io_oe_o <= 1'b0;
                    chip_select_n_o <= '1;
                end else begin
                    addr_out_o <= ADDR_W'(base_r + ADDR_W'(acc_next));
                    data_io_o <= lane_data(word_r, acc_next, asize16_r);
                end
            end
            if (go_setup) begin
                addr_out_o <= req_addr_i;
                bank_addr_out_o <= req_bank_i;
                data_io_o <= lane_data(req_data_i, `ACC_FIRST, cfg_sel.asize16);
                data_io_oe_o <= 1'b1;
                chip_select_n_o <= '1;
                if (!cfg_sel.ss) begin
                    chip_select_n_o[req_space_i] <= 1'b0;
                end
            end
        end
    end

    // Status pulses and busy level
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_accept_o <= 1'b0;
            abandon_o <= 1'b0;
            done_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            req_accept_o <= go_setup;
            abandon_o <= abandon_nxt;
            done_o <= state_r == ST_HOLD && tif.expired && last_acc;
            busy_o <= state_nxt != ST_IDLE;
        end
    end

    // Checks on the pin sequence
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence one_turn_s;
        state_r == ST_TURN ##1 state_r == ST_SETUP;
    endsequence

    turn_skip_a: assert property (state_r == ST_IDLE && req_valid_i && req_top_i && last_wr_r
        |=> state_r == ST_SETUP) else $error("turnaround inserted after a write");
    turn_one_a: assert property (state_r == ST_IDLE && req_valid_i && req_top_i && !last_wr_r
        && cfg_sel.ta == `TA_ZERO ##1 req_valid_i && req_top_i |-> one_turn_s)
        else $error("not exactly one turnaround after a read");
    abandon_chk_a: assert property (state_r == ST_TURN && tif.expired && !req_top_i
        |=> state_r == ST_IDLE && abandon_o) else $error("lost priority not abandoned");
    setup_drive_a: assert property (go_setup
        |=> data_io_oe_o && (ss_r || !chip_select_n_o[space_r])) else $error("setup pins wrong");
    strobe_fall_a: assert property (state_r == ST_SETUP && tif.expired
        |=> !write_strobe_n_o && state_r == ST_STROBE) else $error("strobe did not fall");
    strobe_rise_a: assert property (state_r == ST_STROBE && tif.expired
        |=> write_strobe_n_o && &byte_enable_n_o) else $error("strobe did not end");
    wait_stretch_a: assert property (state_r == ST_STROBE && device_wait_in_i
        |=> state_r == ST_STROBE && !write_strobe_n_o) else $error("wait did not stretch");
    hold_release_a: assert property (state_r == ST_HOLD && tif.expired && last_acc && !go_setup
        |=> !data_io_oe_o && &chip_select_n_o) else $error("bus not released");
    split_keep_a: assert property (state_r == ST_HOLD && tif.expired && !last_acc
        |=> state_r == ST_SETUP && $stable(chip_select_n_o) && $stable(stb_r) && $stable(hld_r))
        else $error("split access mishandled");
    ss_select_a: assert property (state_r == ST_SETUP && ss_r |-> &chip_select_n_o)
        else $error("select active outside strobe");
endmodule // async_wr_seq
`default_nettype wire

// ==== tb/async_mem_model.sv ====
// External asynchronous memory model with a programmable wait stretch
`timescale 1ns/1ns
`default_nettype none
module async_mem_model (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [2:0] wait_len_i,
    input wire logic write_strobe_n_i,
    input wire logic [1:0] byte_enable_n_i,
    input wire logic [3:0] chip_select_n_i,
    input wire logic [22:0] addr_i,
    input wire logic [15:0] data_i,
    output logic device_wait_in_o
);
    logic [15:0] mem [16];
    logic [3:0] last_cs;
    logic [2:0] wait_cnt_r;
    // Holds wait for wait_len cycles of each strobe, so the stretch is exact
    assign device_wait_in_o = !write_strobe_n_i && (wait_cnt_r < wait_len_i);
    // Counter parks while the strobe is high
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) wait_cnt_r <= 3'h0;
        else if (write_strobe_n_i) wait_cnt_r <= 3'h0;
        else if (device_wait_in_o) wait_cnt_r <= wait_cnt_r + 3'h1;
    end
    // Latch data while selected and strobed; lanes gated by byte enables
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
            last_cs = 4'hF;
        end else if (!write_strobe_n_i && chip_select_n_i != 4'hF) begin
            last_cs = chip_select_n_i;
            if (!byte_enable_n_i[0]) mem[addr_i[3:0]][7:0] = data_i[7:0];
            if (!byte_enable_n_i[1]) mem[addr_i[3:0]][15:8] = data_i[15:8];
        end
    end
endmodule // async_mem_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking testbench for the asynchronous write sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
    import async_wr_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    chip_space_config_t cfg;
    logic req_valid = 1'b0, req_top = 1'b0, read_done = 1'b0;
    logic [1:0] req_space = 2'h0, req_bank = 2'h0, be_n, bank;
    logic [22:0] req_addr = 23'h0, addr;
    logic [31:0] req_data = 32'h0;
    logic [3:0] req_be = 4'h0, cs_n;
    logic [2:0] wait_len = 3'h0;
    logic dev_wait, accept, abandon, done, busy, we_n, oe, ab;
    logic [15:0] dout, din;
    int n_errors = 0, check_count = 0, cycles = 0;
    int n_we, n_oe, n_csl, n_csr, n_acc, n_be1, k;
    logic we_prev = 1'b1, cs_prev = 1'b0;
    logic [1:0] bank_seen = 2'h0;

    always #10 core_clk_i = ~core_clk_i;
    // Released pad never shows the stale value
    assign din = oe ? dout : ~dout;

    async_wr_seq async_wr_seq_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .chip_space_config_i(cfg), .req_valid_i(req_valid), .req_top_i(req_top),
        .req_space_i(req_space), .req_addr_i(req_addr), .req_bank_i(req_bank),
        .req_data_i(req_data), .req_be_i(req_be), .read_done_i(read_done),
        .device_wait_in_i(dev_wait), .data_io_i(din), .req_accept_o(accept),
        .abandon_o(abandon), .done_o(done), .busy_o(busy), .write_strobe_n_o(we_n),
        .byte_enable_n_o(be_n), .chip_select_n_o(cs_n), .addr_out_o(addr),
        .bank_addr_out_o(bank), .data_io_o(dout), .data_io_oe_o(oe));
    async_mem_model async_mem_model_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .wait_len_i(wait_len), .write_strobe_n_i(we_n), .byte_enable_n_i(be_n),
        .chip_select_n_i(cs_n), .addr_i(addr), .data_i(dout), .device_wait_in_o(dev_wait));

    // Pin activity counted at the falling edge, clear of the launch edge
    always @(negedge core_clk_i) begin
        // Bank pins sampled while strobed, so the value the device latches
        if (we_n === 1'b0) begin
            n_we++;
            bank_seen = bank;
        end
        if (oe === 1'b1) n_oe++;
        if (cs_n !== 4'hF) n_csl++;
        if (cs_prev && cs_n === 4'hF) n_csr++;
        if (we_prev && we_n === 1'b0) n_acc++;
        if (be_n[1] === 1'b0) n_be1++;
        cs_prev = (cs_n !== 4'hF);
        we_prev = we_n;
    end
    // Hang guard, well above the few hundred cycles needed
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic pulse_read();
        @(posedge core_clk_i) read_done <= 1'b1;
        @(posedge core_clk_i) read_done <= 1'b0;
    endtask

    // One word request; k is edges from launch to accept or abandon
    task automatic do_write(input logic [1:0] sp, input logic [22:0] a,
                            input logic [31:0] d, input logic [3:0] b,
                            input bit drop, input bit poke);
        @(posedge core_clk_i);
        req_valid <= 1'b1;
        req_top <= 1'b1;
        req_space <= sp;
        req_bank <= sp;
        req_addr <= a;
        req_data <= d;
        req_be <= b;
        {n_we, n_oe, n_csl, n_csr, n_acc, n_be1} = '0;
        for (k = 1; k <= 40; k++) begin
            @(posedge core_clk_i);
            if (drop && k == 1) req_top <= 1'b0;
            #1;
            if (accept === 1'b1 || abandon === 1'b1) break;
        end
        `CHK(accept | abandon, 1'b1)
        ab = abandon;
        @(posedge core_clk_i);
        req_valid <= 1'b0;
        req_top <= 1'b0;
        if (poke) cfg[sp].w_strobe <= 6'h0;
        if (!drop) begin
            for (int i = 0; i < 200; i++) begin
                @(posedge core_clk_i);
                #1;
                if (done === 1'b1) break;
            end
            `CHK(done, 1'b1)
        end
        // Let the falling-edge counters settle before anyone reads them
        @(negedge core_clk_i);
        #1;
    endtask

    // Strobe cycles and total driven cycles per access
    task automatic chk_timing(input int acc, input int st, input int ph, input int csr);
        `CHK(n_acc, acc)
        `CHK(n_we, acc * st)
        `CHK(n_oe, acc * ph)
        `CHK(n_csr, csr)
    endtask

    initial begin
        for (int i = 0; i < 4; i++) cfg[i] = '{1'b0, 1'b1, 2'h0, 4'h1, 6'h2, 3'h0};
        repeat (16) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
        `CHK(we_n, 1'b1)
        `CHK(cs_n, 4'hF)
        `CHK(oe, 1'b0)
        // Halfword device straight after reset: no turnaround, select held between halves
        do_write(2'h1, 23'h0, 32'hBEEF1234, 4'hF, 0, 0);
        `CHK(k, 1)
        `CHK(bank_seen, 2'h1)
        `CHK(addr, 23'h0)
        chk_timing(2, 3, 6, 1);
        `CHK(n_csl, n_oe)
        `CHK(async_mem_model_inst.mem[0], 16'h1234)
        `CHK(async_mem_model_inst.mem[1], 16'hBEEF)
        `CHK(async_mem_model_inst.last_cs, 4'hD)
        `CHK(busy, 1'b0)
        // Device stretches each strobe by two cycles
        @(posedge core_clk_i) wait_len <= 3'h2;
        do_write(2'h1, 23'h2, 32'h55667788, 4'hF, 0, 0);
        chk_timing(2, 5, 8, 1);
        @(posedge core_clk_i) wait_len <= 3'h0;
        // After a read a zero count still costs one cycle; after a write none
        pulse_read();
        do_write(2'h0, 23'h4, 32'h0, 4'hF, 0, 0);
        `CHK(k, 2)
        do_write(2'h0, 23'h4, 32'h0, 4'hF, 0, 0);
        `CHK(k, 1)
        @(posedge core_clk_i) cfg[0].ta <= 2'h2;
        pulse_read();
        do_write(2'h0, 23'h4, 32'h0, 4'hF, 0, 0);
        `CHK(k, 3)
        // Config change mid-word must not alter the follow-on access
        do_write(2'h0, 23'h6, 32'h0, 4'hF, 0, 1);
        chk_timing(2, 3, 6, 1);
        @(posedge core_clk_i) cfg[0].w_strobe <= 6'h2;
        // Byte-wide device: four accesses on the low lane only
        @(posedge core_clk_i) cfg[2].asize16 <= 1'b0;
        do_write(2'h2, 23'h8, 32'h44332211, 4'hF, 0, 0);
        chk_timing(4, 3, 6, 1);
        `CHK(n_be1, 0)
        for (int i = 0; i < 4; i++) `CHK(async_mem_model_inst.mem[8 + i], 16'(17 * (i + 1)))
        // Select-strobe space with partial enables: select only while strobed
        @(posedge core_clk_i) cfg[3].ss <= 1'b1;
        do_write(2'h3, 23'hC, 32'hCAFEF00D, 4'h5, 0, 0);
        chk_timing(2, 3, 6, 2);
        `CHK(n_csl, n_we)
        `CHK(async_mem_model_inst.mem[12], 16'h000D)
        `CHK(async_mem_model_inst.mem[13], 16'h00FE)
        `CHK(bank_seen, 2'h3)
        // Word waiting at the last hold end starts its setup on that same edge
        @(posedge core_clk_i) req_valid <= 1'b1;
        req_top <= 1'b1;
        req_space <= 2'h1;
        req_addr <= 23'h4;
        req_data <= 32'h0000AAAA;
        req_be <= 4'hF;
        @(posedge core_clk_i) req_data <= 32'hBBBB1111;
        req_addr <= 23'h6;
        for (k = 0; k < 40; k++) begin
            @(posedge core_clk_i);
            #1;
            if (accept === 1'b1) break;
        end
        `CHK(done, 1'b1)
        @(posedge core_clk_i) req_valid <= 1'b0;
        req_top <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        `CHK(async_mem_model_inst.mem[4], 16'hAAAA)
        `CHK(async_mem_model_inst.mem[6], 16'h1111)
        `CHK(async_mem_model_inst.mem[7], 16'hBBBB)
        // Priority lost during turnaround drops the request untouched
        pulse_read();
        do_write(2'h0, 23'hE, 32'h0, 4'hF, 1, 0);
        `CHK(ab, 1'b1)
        `CHK(n_acc, 0)
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
